// File: design/wdsc_regs.svh
// register indices, bit positions, reset values and timing for the watchdog
`ifndef WDSC_REGS_SVH
`define WDSC_REGS_SVH
// ---------------------------------------------------------------
// register indices (byte address is index shifted left by two)
// ---------------------------------------------------------------
`define WDSC_ADDR_W        16
`define WDSC_IDX_SHIFT     2
`define WDSC_OPTION_IDX    16'h0081
`define WDSC_CONFIG_IDX    16'h2007
`define WDSC_STATUS_IDX    16'h0003
`define WDSC_CONTROL_IDX   16'h0004
`define WDSC_IRQEN_IDX     16'h000B
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define WDSC_OPTION_RESET  8'hFF
`define WDSC_OPT_OWNER     3
`define WDSC_OPT_RATIO_HI  2
`define WDSC_OPT_RATIO_LO  0
`define WDSC_CFG_FUSE      2
`define WDSC_ST_EXPIRY_N   4
`define WDSC_ST_SLEEP_N    3
`define WDSC_ST_ASLEEP     0
`define WDSC_CTL_KICK      0
`define WDSC_CTL_SLEEP     1
`define WDSC_IE_GLOBAL     7
`define WDSC_IRQ_N         3
`define WDSC_IRQ_HI        2
`define WDSC_WAKE_MASK     3'h7
// ---------------------------------------------------------------
// widths and timing
// ---------------------------------------------------------------
`define WDSC_CNT_W         20
`define WDSC_PRE_W         7
`define WDSC_BASE_PERIOD_US 18000
`define WDSC_CLOCK_MHZ     50
`endif

// File: design/wdsc_pkg.sv
// types shared by the watchdog and sleep control block
package wdsc_pkg;
  `include "wdsc_regs.svh"

  typedef enum logic [0:0] {
    WDSC_RUN   = 1'b0,
    WDSC_SLEEP = 1'b1
  } wdsc_mode_e;

  typedef struct packed {
    wdsc_mode_e                   mode;
    logic [2:0]                   pinSync;
    logic                         pinLevel;
    logic                         cfgTaken;
    logic [7:0]                   configWord;
    logic [7:0]                   optionControl;
    logic [`WDSC_IRQ_N-1:0]       irqEnable;
    logic                         globalIrqEnable;
    logic                         watchdogExpiryFlag_n;
    logic                         sleepEnteredFlag_n;
    logic [`WDSC_CNT_W-1:0]       watchdogCounter;
    logic [`WDSC_PRE_W-1:0]       prescaleCount;
    logic                         deviceReset;
    logic                         coreClockEnable;
    logic                         portHold;
    logic                         wakeup;
    logic                         vectorToIrq;
    logic                         prefetchNext;
    logic                         watchdogExpired;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } wdsc_state_s;
endpackage

// File: design/wdsc_top.sv
// watchdog timer with prescaler, sleep entry and wake-up control
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module wdsc_top
  import wdsc_pkg::*;
#(
  parameter int BASE_CYCLES =
    `WDSC_BASE_PERIOD_US * `WDSC_CLOCK_MHZ,
  parameter logic [`WDSC_IRQ_N-1:0] WAKE_MASK = `WDSC_WAKE_MASK
) (
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`WDSC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [7:0]               configStrap,
  input  wire logic                     externalResetPin_b,
  input  wire logic [`WDSC_IRQ_N-1:0]   irqFlag,
  output logic                          deviceReset,
  output logic                          coreClockEnable,
  output logic                          portHold,
  output logic                          wakeup,
  output logic                          vectorToIrq,
  output logic                          prefetchNext,
  output logic                          watchdogExpired,
  output logic                          watchdogExpiryFlag_n,
  output logic                          sleepEnteredFlag_n
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (BASE_CYCLES < 1 || BASE_CYCLES >= (1 << `WDSC_CNT_W)) begin : gChk
    $error("BASE_CYCLES does not fit the watchdog counter");
  end

  localparam logic [`WDSC_CNT_W-1:0] BASE_LAST =
    `WDSC_CNT_W'(BASE_CYCLES - 1);

  localparam wdsc_state_s RESET_STATE = '{
    mode:                 WDSC_RUN,
    pinSync:              3'h7,
    pinLevel:             1'b1,
    cfgTaken:             1'b0,
    configWord:           8'h00,
    optionControl:        `WDSC_OPTION_RESET,
    irqEnable:            '0,
    globalIrqEnable:      1'b0,
    watchdogExpiryFlag_n: 1'b1,
    sleepEnteredFlag_n:   1'b1,
    watchdogCounter:      '0,
    prescaleCount:        '0,
    deviceReset:          1'b0,
    coreClockEnable:      1'b1,
    portHold:             1'b0,
    wakeup:               1'b0,
    vectorToIrq:          1'b0,
    prefetchNext:         1'b0,
    watchdogExpired:      1'b0,
    pready:               1'b0,
    pslverr:              1'b0,
    prdata:               32'h0000_0000
  };

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [`WDSC_ADDR_W-1:0] regAddr(
    input logic [`WDSC_ADDR_W-1:0] idx);
    regAddr = idx << `WDSC_IDX_SHIFT;
  endfunction

  function automatic logic isReg(input logic [`WDSC_ADDR_W-1:0] a,
                                 input logic [`WDSC_ADDR_W-1:0] idx);
    isReg = (a == regAddr(idx));
  endfunction

  // last prescaler count before expiry: ratio 1:2^field
  function automatic logic [`WDSC_PRE_W-1:0] ratioLast(
    input logic [2:0] field);
    ratioLast = `WDSC_PRE_W'((8'h01 << field) - 8'h01);
  endfunction

  // everything a device reset returns to its start value
  function automatic wdsc_state_s coreReset(input wdsc_state_s x);
    coreReset                 = x;
    coreReset.watchdogCounter = '0;
    coreReset.prescaleCount   = '0;
    coreReset.optionControl   = `WDSC_OPTION_RESET;
    coreReset.irqEnable       = '0;
    coreReset.globalIrqEnable = 1'b0;
    coreReset.mode            = WDSC_RUN;
    coreReset.coreClockEnable = 1'b1;
    coreReset.portHold        = 1'b0;
    coreReset.deviceReset     = 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wdsc_state_s                state;
  wdsc_state_s                next_state;
  logic                       access;
  logic                       doWrite;
  logic                       hit;
  logic                       kick;
  logic                       sleepCmd;
  logic                       wdOn;
  logic                       expire;
  logic                       pinReset;
  logic [`WDSC_IRQ_N-1:0]     enabledFlags;
  logic [2:0]                 ratioField;
  logic                       ownerIsWatchdog;

  always_comb begin
    next_state = state;
    next_state.deviceReset     = 1'b0;
    next_state.wakeup          = 1'b0;
    next_state.vectorToIrq     = 1'b0;
    next_state.prefetchNext    = 1'b0;
    next_state.watchdogExpired = 1'b0;
    next_state.pready          = 1'b0;
    next_state.pslverr         = 1'b0;

    // reset pin: three flops, level taken once the last two agree
    next_state.pinSync = {state.pinSync[1:0], externalResetPin_b};
    if (state.pinSync[2] == state.pinSync[1]) begin
      next_state.pinLevel = state.pinSync[2];
    end
    pinReset = ~state.pinLevel;

    // fuse word is sampled once, on the first edge after reset release
    next_state.cfgTaken = 1'b1;
    if (!state.cfgTaken) begin
      next_state.configWord = configStrap;
    end
    wdOn = state.cfgTaken & state.configWord[`WDSC_CFG_FUSE];

    // ---------------------------------------------------------------
    // register bus: one wait state, answer registered
    // ---------------------------------------------------------------
    access = psel & penable;
    hit    = isReg(paddr, `WDSC_OPTION_IDX)  |
             isReg(paddr, `WDSC_CONFIG_IDX)  |
             isReg(paddr, `WDSC_STATUS_IDX)  |
             isReg(paddr, `WDSC_CONTROL_IDX) |
             isReg(paddr, `WDSC_IRQEN_IDX);
    if (access && !state.pready) begin
      next_state.pready  = 1'b1;
      next_state.pslverr = ~hit;
      next_state.prdata  = 32'h0000_0000;
      if (isReg(paddr, `WDSC_OPTION_IDX)) begin
        next_state.prdata[7:0] = state.optionControl;
      end
      if (isReg(paddr, `WDSC_CONFIG_IDX)) begin
        next_state.prdata[7:0] = state.configWord;
      end
      if (isReg(paddr, `WDSC_STATUS_IDX)) begin
        next_state.prdata[`WDSC_ST_EXPIRY_N] =
          state.watchdogExpiryFlag_n;
        next_state.prdata[`WDSC_ST_SLEEP_N]  = state.sleepEnteredFlag_n;
        next_state.prdata[`WDSC_ST_ASLEEP]   = (state.mode == WDSC_SLEEP);
      end
      if (isReg(paddr, `WDSC_IRQEN_IDX)) begin
        next_state.prdata[`WDSC_IRQ_HI:0]  = state.irqEnable;
        next_state.prdata[`WDSC_IE_GLOBAL] = state.globalIrqEnable;
      end
    end
    doWrite  = access & pwrite & state.pready & ~state.pslverr;
    kick     = doWrite & isReg(paddr, `WDSC_CONTROL_IDX) &
               pwdata[`WDSC_CTL_KICK];
    sleepCmd = doWrite & isReg(paddr, `WDSC_CONTROL_IDX) &
               pwdata[`WDSC_CTL_SLEEP];
    if (doWrite && isReg(paddr, `WDSC_OPTION_IDX)) begin
      next_state.optionControl = pwdata[7:0];
    end
    if (doWrite && isReg(paddr, `WDSC_IRQEN_IDX)) begin
      next_state.irqEnable       = pwdata[`WDSC_IRQ_HI:0];
      next_state.globalIrqEnable = pwdata[`WDSC_IE_GLOBAL];
    end

    // ---------------------------------------------------------------
    // watchdog counting: keeps going whatever the core clock does
    // ---------------------------------------------------------------
    ownerIsWatchdog = state.optionControl[`WDSC_OPT_OWNER];
    ratioField = state.optionControl[`WDSC_OPT_RATIO_HI:
                                     `WDSC_OPT_RATIO_LO];
    expire = 1'b0;
    if (wdOn) begin
      if (state.watchdogCounter == BASE_LAST) begin
        next_state.watchdogCounter = '0;
        if (!ownerIsWatchdog) begin
          expire = 1'b1;
        end else if (state.prescaleCount == ratioLast(ratioField)) begin
          next_state.prescaleCount = '0;
          expire = 1'b1;
        end else begin
          next_state.prescaleCount = state.prescaleCount + 1'b1;
        end
      end else begin
        next_state.watchdogCounter = state.watchdogCounter + 1'b1;
      end
    end

    // interrupts with both flag and individual enable set
    enabledFlags = irqFlag & state.irqEnable;

    // ---------------------------------------------------------------
    // priority: reset pin, expiry, sleeping, sleep command, kick
    // ---------------------------------------------------------------
    if (pinReset) begin
      // held in reset for as long as the pin stays low
      next_state = coreReset(next_state);
    end else if (expire) begin
      next_state.watchdogExpired      = 1'b1;
      next_state.watchdogExpiryFlag_n = 1'b0;
      next_state.watchdogCounter      = '0;
      next_state.prescaleCount        = '0;
      if (state.mode == WDSC_SLEEP) begin
        next_state.mode            = WDSC_RUN;
        next_state.coreClockEnable = 1'b1;
        next_state.portHold        = 1'b0;
        next_state.wakeup          = 1'b1;
      end else begin
        next_state = coreReset(next_state);
      end
    end else if (state.mode == WDSC_SLEEP) begin
      // an enabled WAKE_MASK interrupt raised once asleep wakes us here; one already raised at the sleep write blocks entry
      if (|(enabledFlags & WAKE_MASK)) begin
        next_state.mode            = WDSC_RUN;
        next_state.coreClockEnable = 1'b1;
        next_state.portHold        = 1'b0;
        next_state.wakeup          = 1'b1;
        next_state.vectorToIrq     = state.globalIrqEnable;
      end
    end else if (sleepCmd) begin
      next_state.prefetchNext = 1'b1;
      if (enabledFlags == '0) begin
        next_state.watchdogCounter    = '0;
        next_state.prescaleCount      = '0;
        next_state.sleepEnteredFlag_n = 1'b0;
        next_state.watchdogExpiryFlag_n = 1'b1;
        next_state.mode               = WDSC_SLEEP;
        next_state.coreClockEnable    = 1'b0;
        next_state.portHold           = 1'b1;
      end
    end else if (kick) begin
      // ratio and owner bits are untouched, only the counts clear
      next_state.watchdogCounter = '0;
      next_state.prescaleCount   = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs straight from the state register
  // ---------------------------------------------------------------
  assign prdata               = state.prdata;
  assign pready               = state.pready;
  assign pslverr              = state.pslverr;
  assign deviceReset          = state.deviceReset;
  assign coreClockEnable      = state.coreClockEnable;
  assign portHold             = state.portHold;
  assign wakeup               = state.wakeup;
  assign vectorToIrq          = state.vectorToIrq;
  assign prefetchNext         = state.prefetchNext;
  assign watchdogExpired      = state.watchdogExpired;
  assign watchdogExpiryFlag_n = state.watchdogExpiryFlag_n;
  assign sleepEnteredFlag_n   = state.sleepEnteredFlag_n;

endmodule

// File: tb/wdsc_props.sv
// concurrent checks on the watchdog and sleep control ports
`timescale 1ns/100ps
module wdsc_props (
  input logic clock,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic deviceReset,
  input logic coreClockEnable,
  input logic portHold,
  input logic wakeup,
  input logic vectorToIrq,
  input logic prefetchNext,
  input logic watchdogExpired,
  input logic watchdogExpiryFlag_n,
  input logic sleepEnteredFlag_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late");
  AST_SLVERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_EXP_FLAG: assert property (watchdogExpired |-> ##[0:1] !watchdogExpiryFlag_n)
    else $error("expiry flag not cleared");
  AST_RUN_RESET: assert property (watchdogExpired && !$past(portHold) |-> ##[0:1] deviceReset)
    else $error("no reset on expiry");
  AST_SLEEP_WAKE: assert property (watchdogExpired && $past(portHold) |-> !deviceReset ##0 (##[0:1] wakeup))
    else $error("asleep expiry mishandled");
  AST_ENTRY: assert property ($rose(portHold) |-> !coreClockEnable && !sleepEnteredFlag_n && watchdogExpiryFlag_n && prefetchNext)
    else $error("sleep entry state wrong");
  AST_EXIT: assert property ($fell(portHold) |-> wakeup || deviceReset)
    else $error("sleep left without cause");
  AST_VECTOR: assert property (vectorToIrq |-> wakeup && !watchdogExpired)
    else $error("vector without interrupt wake");
  AST_WAKE_ONCE: assert property (wakeup |=> !wakeup && !portHold && coreClockEnable)
    else $error("wake pulse or hold wrong");

  cover property ($rose(portHold));
  cover property (wakeup && vectorToIrq);
  cover property (watchdogExpired && deviceReset);
  cover property (pslverr);
endmodule

// File: tb/wdsc_tb_top.sv
// self-checking bench for the watchdog and sleep control block
`timescale 1ns/100ps
`include "wdsc_regs.svh"
module wdsc_tb_top;
  localparam int BC = 20;
  localparam logic [15:0] A_OPT = `WDSC_OPTION_IDX << 2;
  localparam logic [15:0] A_CFG = `WDSC_CONFIG_IDX << 2;
  localparam logic [15:0] A_ST  = `WDSC_STATUS_IDX << 2;
  localparam logic [15:0] A_CTL = `WDSC_CONTROL_IDX << 2;
  localparam logic [15:0] A_IE  = `WDSC_IRQEN_IDX << 2;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  configStrap = 8'h04;
  logic        externalResetPin_b = 1'b1; // pin starts high; tPin pulls it low while asleep
  logic [2:0]  irqFlag = 3'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, deviceReset, coreClockEnable, portHold;
  logic        wakeup, vectorToIrq, prefetchNext, watchdogExpired;
  logic        watchdogExpiryFlag_n, sleepEnteredFlag_n;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          n;
  logic [32:0] r;

  wdsc_top #(.BASE_CYCLES(BC)) dut (.clock, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .configStrap,
    .externalResetPin_b, .irqFlag, .deviceReset, .coreClockEnable,
    .portHold, .wakeup, .vectorToIrq, .prefetchNext, .watchdogExpired,
    .watchdogExpiryFlag_n, .sleepEnteredFlag_n);

  always #10 clock = ~clock;

  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // request stands until pready is sampled high at a rising edge
    do @(posedge clock); while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(r[31:0], e, "read");
  endtask

  // counts whole cycles until the watched output is seen high
  task automatic waitHi(ref logic s);
    n = 0;
    while (s !== 1'b1) begin
      @(negedge clock);
      n++;
    end
  endtask

  task automatic tRegs;
    rd(A_OPT, 32'hFF);
    apb(1'b1, A_OPT, 32'h0B);
    rd(A_OPT, 32'h0B);
    rd(A_CFG, 32'h04);
    apb(1'b1, A_ST, 32'h0);
    rd(A_ST, 32'h18);
    apb(1'b0, 16'h0100, 32'h0);
    check(r, 33'h100000000, "unmapped");
    $display("register test done");
  endtask

  task automatic tNoop;
    apb(1'b1, A_IE, 32'h01);
    irqFlag <= 3'h1;
    apb(1'b1, A_CTL, 32'h02);
    @(negedge clock);
    check({prefetchNext, portHold}, 2'b10, "no-op sleep");
    irqFlag <= 3'h0;
    rd(A_ST, 32'h18);
    $display("no-op sleep test done");
  endtask

  task automatic tPeriod;
    logic [7:0] opt [5] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h07};
    int         mul [5] = '{1, 2, 4, 8, 1};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, A_OPT, {24'h0, opt[i]});
      apb(1'b1, A_CTL, 32'h01);
      waitHi(watchdogExpired);
      // two cycles of slack for the registered expiry outputs
      check(n >= BC * mul[i] && n <= BC * mul[i] + 2, 1, "period");
      @(negedge clock);
      check(watchdogExpiryFlag_n, 1'b0, "expiry flag");
    end
    $display("period test done");
  endtask

  task automatic tKick;
    apb(1'b1, A_OPT, 32'h09);
    repeat (3) begin
      repeat (30) @(negedge clock);
      check(watchdogExpired, 1'b0, "early expiry");
      apb(1'b1, A_CTL, 32'h01);
    end
    rd(A_OPT, 32'h09);
    waitHi(watchdogExpired);
    check(n <= 2 * BC + 2, 1, "kick restart");
    $display("kick test done");
  endtask

  task automatic tSleepWdt;
    apb(1'b1, A_OPT, 32'h00);
    apb(1'b1, A_CTL, 32'h01); // kick before sleeping
    apb(1'b1, A_CTL, 32'h02);
    @(negedge clock);
    check({prefetchNext, portHold, coreClockEnable, sleepEnteredFlag_n,
           watchdogExpiryFlag_n}, 5'b11001, "entry");
    waitHi(watchdogExpired);
    check(n <= BC + 2, 1, "asleep period");
    check(deviceReset, 1'b0, "asleep reset");
    repeat (2) @(negedge clock);
    check(portHold, 1'b0, "woken");
    rd(A_ST, 32'h00);
    $display("sleep watchdog test done");
  endtask

  task automatic tSleepIrq;
    apb(1'b1, A_OPT, 32'hFF);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, A_IE, (32'h1 << s) | ((s == 1) ? 32'h80 : 32'h0));
      apb(1'b1, A_CTL, 32'h02);
      irqFlag <= ~(3'h1 << s);
      repeat (5) @(negedge clock);
      check(portHold, 1'b1, "unenabled wake");
      @(posedge clock);
      irqFlag <= 3'h7;
      waitHi(wakeup);
      check(vectorToIrq, s == 1, "vector");
      check(n <= 3, 1, "wake delay");
      @(posedge clock);
      irqFlag <= 3'h0;
    end
    $display("sleep interrupt test done");
  endtask

  task automatic tPin;
    apb(1'b1, A_IE, 32'h0);
    apb(1'b1, A_CTL, 32'h02);
    externalResetPin_b <= 1'b0;
    waitHi(deviceReset);
    check(n <= 6, 1, "pin reset delay");
    @(negedge clock);
    check(portHold, 1'b0, "pin wake");
    @(posedge clock);
    externalResetPin_b <= 1'b1;
    repeat (8) @(posedge clock);
    $display("pin reset test done");
  endtask

  task automatic tFuse;
    configStrap <= 8'h00;
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(A_CFG, 32'h00);
    apb(1'b1, A_OPT, 32'h00);
    n = 0;
    repeat (4 * BC) begin
      @(negedge clock);
      n += watchdogExpired;
    end
    check(n, 0, "fuse off");
    $display("fuse test done");
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    tRegs();
    tNoop();
    tPeriod();
    tKick();
    tSleepWdt();
    tSleepIrq();
    tPin();
    tFuse();
    results();
  end
endmodule

bind wdsc_top wdsc_props u_props (.clock, .rst_b, .psel, .penable,
  .pready, .pslverr, .deviceReset, .coreClockEnable, .portHold, .wakeup,
  .vectorToIrq, .prefetchNext, .watchdogExpired, .watchdogExpiryFlag_n,
  .sleepEnteredFlag_n);
